// ### tpp_pkg.sv
/*
 * Constants, field layouts and types for the threshold PROM programming
 * block. Assumes a 250 MHz core clock; the entry, window, end-of-word and exit cycle counts are derived here.
 */
package tpp_pkg;

    localparam int CLK_PERIOD_NS  = 4;
    localparam int NS_PER_US      = 1000;
    localparam int NS_PER_MS      = 1000000;

    // Timing figures in their own units, then converted to cycles.
    localparam int ENTRY_LOW_MS   = 1;
    localparam int ENTRY_WIN_MS   = 2;
    localparam int EOW_LOW_US     = 170;
    localparam int EXIT_HIGH_US   = 1000;
    localparam int ENTRY_LOW_CYC0 = ENTRY_LOW_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int ENTRY_WIN_CYC0 = ENTRY_WIN_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int EOW_CYC0       = EOW_LOW_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int EXIT_CYC0      = EXIT_HIGH_US * NS_PER_US / CLK_PERIOD_NS;

    // Internal clock used by the search: one period in core cycles.
    localparam int INT_CLK_CYC    = 16;

    localparam int CNT_W          = 20;
    localparam int THR_W          = 8;
    localparam int FACTOR_W       = 3;
    localparam int WORD_W         = 14;
    localparam int DATA_W         = 13;
    localparam int IDX_W          = 3;
    localparam int TICK_W         = 4;
    localparam int BITCNT_W       = 4;

    // Data word layout, bit 0 received first.
    localparam int HEAD_HI        = 12;
    localparam int HEAD_LO        = 10;
    localparam int FACTOR_HI      = 4;
    localparam int FACTOR_LO      = 2;
    localparam int INV_POS        = 1;
    localparam int TAIL_POS       = 0;

    localparam logic [2:0]        HEAD_PATTERN = 3'h5;
    localparam logic [DATA_W-1:0] COPY_WORD2   = 13'h17FF;
    localparam logic [THR_W-1:0]  SAR_START    = 8'h80;
    localparam logic [IDX_W-1:0]  SAR_TOP_IDX  = 3'h7;
    localparam logic [BITCNT_W-1:0] BITS_FULL  = 4'hE;

    typedef logic [CNT_W-1:0] tpp_cnt_t;

    typedef enum logic [2:0] {
        MD_ENTRY,
        MD_RUN,
        MD_SAR,
        MD_TEST
    } tpp_mode_t;

endpackage : tpp_pkg

// ### tpp_link_if.sv
/*
 * Carrier between the supply-clocked receiver and the core logic.
 * Assumes the word is only read after the bit toggle has settled.
 */
`timescale 1ns/1ns
interface tpp_link_if;
    logic [13:0] word;
    logic        tgl;

    modport rx   (output word, output tgl);
    modport core (input word, input tgl);
endinterface : tpp_link_if

// ### tpp_link_rx.sv
/*
 * Supply-pulse receiver: shifts one bit per rising link clock edge, newest bit at
 * the top, and flips a toggle per bit. Assumes the link clock may stop.
 */
`timescale 1ns/1ns
module tpp_link_rx
    import tpp_pkg::*;
(
    input  wire logic link_clk,
    input  wire logic rst_n,
    input  wire logic link_data,
    tpp_link_if.rx    lnk
);

    // Extra bits push the oldest out, so only the last word stays.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk.word <= '0;
            lnk.tgl  <= 1'b0;
        end else begin
            lnk.word <= {link_data, lnk.word[WORD_W-1:1]};
            lnk.tgl  <= ~lnk.tgl;
        end
    end

endmodule : tpp_link_rx

// ### tpp_prog.sv
/*
 * Threshold PROM programming core: test mode entry, offset search, copy
 * command decode and PROM burn strobe. Assumes the fuse array reports its
 * state on FUSE_* and burns when BURN pulses; analog inputs are async.
 */
`timescale 1ns/1ns
module tpp_prog
    import tpp_pkg::*;
#(
    parameter int ENTRY_LOW_CYC = ENTRY_LOW_CYC0,
    parameter int ENTRY_WIN_CYC = ENTRY_WIN_CYC0,
    parameter int EOW_CYC       = EOW_CYC0,
    parameter int EXIT_CYC      = EXIT_CYC0
)(
    input  wire logic                CLK,
    input  wire logic                RST_N,
    input  wire logic                LINK_CLK,
    input  wire logic                LINK_DATA,
    input  wire logic                SUPPLY_HIGH,
    input  wire logic                SYNC_ENTRY,
    input  wire logic                FIELD_ABOVE,
    input  wire logic                DAC_ABOVE,
    input  wire logic                CAL_DONE,
    input  wire logic [THR_W-1:0]    CAL_THRESHOLD,
    input  wire logic                FUSE_PROGRAMMED,
    input  wire logic                FUSE_INV,
    input  wire logic                Q_I,
    output logic                     Q_O,
    output logic                     Q_OE,
    output logic                     TEST_MODE,
    output logic                     SAR_BUSY,
    output logic [THR_W-1:0]         DAC_CODE,
    output logic                     BURN,
    output logic [THR_W-1:0]         BURN_THRESHOLD,
    output logic [FACTOR_W-1:0]      BURN_FACTOR,
    output logic                     BURN_INV
);

    localparam int SAR_MAX = 200;

    tpp_link_if lnk ();

    tpp_link_rx u_rx (
        .link_clk  (LINK_CLK),
        .rst_n     (RST_N),
        .link_data (LINK_DATA),
        .lnk       (lnk.rx)
    );

    // Synchronisers: s1 is read only by s2.
    logic [5:0] s1;
    logic [5:0] s2;
    logic       tgl_d;
    logic       sync_d;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1 <= '0;
            s2 <= '0;
        end else begin
            s1 <= {lnk.tgl, DAC_ABOVE, FIELD_ABOVE, SYNC_ENTRY, ~Q_I,
                   SUPPLY_HIGH};
            s2 <= s1;
        end
    end

    wire sup_high  = s2[0];
    wire q_low     = s2[1];
    wire sync_lvl  = s2[2];
    wire field_hi  = s2[3];
    wire dac_hi    = s2[4];
    wire tgl_s     = s2[5];
    wire bit_seen  = tgl_s ^ tgl_d;
    wire sync_rise = sync_lvl & ~sync_d;

    tpp_mode_t      mode;
    tpp_cnt_t       low_cnt;
    tpp_cnt_t       high_cnt;
    tpp_cnt_t       qlow_cnt;
    tpp_cnt_t       win_cnt;
    logic [BITCNT_W-1:0] bit_cnt;
    logic [TICK_W-1:0]   tick_cnt;
    logic [IDX_W-1:0]    sar_idx;
    logic           armed;
    logic           src_sar;
    logic [FACTOR_W-1:0] factor_hold;
    logic           inv_hold;

    // Supply level timers that mark end of word and end of session.
    wire eow     = ~sup_high && (low_cnt == tpp_cnt_t'(EOW_CYC - 1));
    wire exit_hi = sup_high && (high_cnt == tpp_cnt_t'(EXIT_CYC - 1));
    wire low_sat = (low_cnt == tpp_cnt_t'(EOW_CYC));
    wire [CNT_W-1:0] low_inc  = low_cnt + 1'b1;
    wire [CNT_W-1:0] high_inc = high_cnt + 1'b1;
    wire [CNT_W-1:0] qlow_inc = qlow_cnt + 1'b1;
    wire [CNT_W-1:0] win_inc  = win_cnt + 1'b1;

    // The shift register is copied once its toggle has crossed, while the
    // link clock is a whole bit away from changing it again.
    logic [DATA_W-1:0] word_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            word_q <= '0;
        else if (bit_seen)
            word_q <= lnk.word[DATA_W-1:0];
    end

    wire [DATA_W-1:0] data    = word_q;
    wire word_ok = eow && (bit_cnt == BITS_FULL);
    wire w1_hit  = (data[HEAD_HI:HEAD_LO] == HEAD_PATTERN)
                   && data[TAIL_POS];
    wire w2_hit  = (data == COPY_WORD2);
    // The fixed second word also has the header shape, so it must not
    // arm a further copy by itself.
    wire w1_take = word_ok && w1_hit && !w2_hit;
    wire src_ok  = src_sar | CAL_DONE;
    wire commit  = (mode == MD_TEST) && word_ok && armed && w2_hit
                   && src_ok && !FUSE_PROGRAMMED;

    wire entry_low = (mode == MD_ENTRY) && q_low && !FUSE_PROGRAMMED
                     && (qlow_cnt == tpp_cnt_t'(ENTRY_LOW_CYC - 1));
    wire win_end   = (mode == MD_ENTRY)
                     && (win_cnt == tpp_cnt_t'(ENTRY_WIN_CYC - 1));
    wire sync_go   = (mode == MD_RUN) && sync_rise
                     && !FUSE_PROGRAMMED;

    // One search step per internal clock period.
    wire tick      = (tick_cnt == TICK_W'(INT_CLK_CYC - 1));
    wire [THR_W-1:0] trial = THR_W'(1) << sar_idx;
    wire [THR_W-1:0] kept  = dac_hi ? (DAC_CODE & ~trial) : DAC_CODE;
    wire [THR_W-1:0] next_dac  = kept | (trial >> 1);
    wire sar_last  = tick && (sar_idx == '0);

    tpp_mode_t next_mode;
    always_comb begin
        next_mode = mode;
        case (mode)
            MD_ENTRY: begin
                if (entry_low)
                    next_mode = MD_SAR;
                else if (win_end)
                    next_mode = MD_RUN;
            end
            MD_RUN: begin
                if (sync_go)
                    next_mode = MD_TEST;
            end
            MD_SAR: begin
                if (sar_last)
                    next_mode = MD_TEST;
            end
            MD_TEST: begin
                if (exit_hi)
                    next_mode = MD_RUN;
            end
            default: next_mode = MD_RUN;
        endcase
    end

    // Test mode holds after a burn; only the long high ends it.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            mode <= MD_ENTRY;
        else
            mode <= next_mode;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tgl_d    <= 1'b0;
            sync_d   <= 1'b0;
            low_cnt  <= '0;
            high_cnt <= '0;
            qlow_cnt <= '0;
            win_cnt  <= '0;
        end else begin
            tgl_d    <= tgl_s;
            sync_d   <= sync_lvl;
            // Saturating one past the mark makes end of word a single pulse.
            low_cnt  <= sup_high ? '0 : (low_sat ? low_cnt : low_inc);
            high_cnt <= (!sup_high || exit_hi) ? '0 : high_inc;
            qlow_cnt <= q_low ? qlow_inc : '0;
            win_cnt  <= (mode == MD_ENTRY) ? win_inc : '0;
        end
    end

    // A bit arriving with the end of word still counts (set wins).
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            bit_cnt <= '0;
        else if (bit_seen)
            bit_cnt <= (bit_cnt == BITS_FULL) ? bit_cnt : bit_cnt + 1'b1;
        else if (eow)
            bit_cnt <= '0;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_cnt <= '0;
            sar_idx  <= SAR_TOP_IDX;
            DAC_CODE <= '0;
        end else if (entry_low) begin
            tick_cnt <= '0;
            sar_idx  <= SAR_TOP_IDX;
            DAC_CODE <= SAR_START;
        end else if (mode == MD_SAR) begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
            if (tick) begin
                DAC_CODE <= next_dac;
                sar_idx  <= sar_idx - 1'b1;
            end
        end
    end

    // Word one arms the copy; any other word disarms it.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            armed       <= 1'b0;
            src_sar     <= 1'b0;
            factor_hold <= '0;
            inv_hold    <= 1'b0;
        end else begin
            if (entry_low)
                src_sar <= 1'b1;
            else if (sync_go)
                src_sar <= 1'b0;
            if (mode != MD_TEST)
                armed <= 1'b0;
            else if (eow)
                armed <= w1_take;
            if (w1_take) begin
                factor_hold <= data[FACTOR_HI:FACTOR_LO];
                inv_hold    <= data[INV_POS];
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BURN           <= 1'b0;
            BURN_THRESHOLD <= '0;
            BURN_FACTOR    <= '0;
            BURN_INV       <= 1'b0;
        end else begin
            BURN <= commit;
            if (commit) begin
                BURN_THRESHOLD <= src_sar ? DAC_CODE : CAL_THRESHOLD;
                BURN_FACTOR    <= factor_hold;
                BURN_INV       <= inv_hold;
            end
        end
    end

    // Open drain output: released during entry watch and test mode so
    // the pull-up and the programmer own the line.
    wire inverted  = FUSE_PROGRAMMED && !FUSE_INV;
    wire drive_low = (mode == MD_RUN) && (inverted ? !field_hi : field_hi);
    assign Q_O = 1'b0;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            Q_OE      <= 1'b0;
            TEST_MODE <= 1'b0;
            SAR_BUSY  <= 1'b0;
        end else begin
            Q_OE      <= drive_low;
            TEST_MODE <= (next_mode == MD_TEST) || (next_mode == MD_SAR);
            SAR_BUSY  <= (next_mode == MD_SAR);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_burn_cause;
        BURN |-> $past(word_ok && armed && w2_hit && !FUSE_PROGRAMMED);
    endproperty
    a_burn_cause: assert property (p_burn_cause)
        else $error("Burn without a complete copy command.");

    property p_arm_head;
        $rose(armed) |-> $past(data[HEAD_HI:HEAD_LO] == HEAD_PATTERN);
    endproperty
    a_arm_head: assert property (p_arm_head)
        else $error("Copy armed by a word without the header.");

    property p_factor;
        commit |=> BURN_FACTOR == $past(factor_hold);
    endproperty
    a_factor: assert property (p_factor)
        else $error("Burned factor differs from first word.");

    property p_inv;
        commit |=> BURN_INV == $past(inv_hold) && BURN;
    endproperty
    a_inv: assert property (p_inv)
        else $error("Burned inversion bit differs from first word.");

    property p_exit;
        (mode == MD_TEST) && exit_hi |=> !TEST_MODE && mode == MD_RUN;
    endproperty
    a_exit: assert property (p_exit)
        else $error("Long high level did not end test mode.");

    property p_entry;
        entry_low |=> mode == MD_SAR ##1 SAR_BUSY;
    endproperty
    a_entry: assert property (p_entry)
        else $error("Output low entry did not start the search.");

    property p_sar_done;
        $rose(mode == MD_SAR) |-> ##[1:SAR_MAX] mode == MD_TEST;
    endproperty
    a_sar_done: assert property (p_sar_done)
        else $error("Search did not finish in time.");

    property p_refuse;
        (mode == MD_RUN) && FUSE_PROGRAMMED |=> mode == MD_RUN;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("Programmed device entered test mode.");

    property p_stay;
        BURN && !exit_hi |=> mode == MD_TEST;
    endproperty
    a_stay: assert property (p_stay)
        else $error("Device left test mode right after burning.");

    property p_short_word;
        eow && (bit_cnt != BITS_FULL) |=> !armed && !BURN;
    endproperty
    a_short_word: assert property (p_short_word)
        else $error("Short word was accepted.");

    c_burn:  cover property (BURN);
    c_sar:   cover property (sar_last);
    c_sync:  cover property (sync_go);
    c_exit:  cover property ((mode == MD_TEST) && exit_hi);

endmodule : tpp_prog

// ### tpp_programmer.sv
/*
 * Behavioural end-of-line programmer: modulates the supply to clock the
 * serial link and can pull the open-drain output low. Assumes a 48 ns
 * bit period and a supply that idles below the high level.
 */
`timescale 1ns/1ns
module tpp_programmer #(
    parameter int EOW_NS  = 300,
    parameter int EXIT_NS = 300
)(
    output logic link_clk,
    output logic link_data,
    output logic supply_high,
    output logic pull_low
);
    initial begin
        link_clk    = 1'b0;
        link_data   = 1'b0;
        supply_high = 1'b0;
        pull_low    = 1'b0;
    end

    task automatic hold_low(input logic on);
        pull_low = on;
    endtask : hold_low

    // A one is a long high phase, a zero a short one; the clock rises mid bit.
    task automatic send_bit(input logic b);
        supply_high = 1'b1;
        link_data   = b;
        #16 supply_high = b;
        #8 link_clk = 1'b1;
        #8 supply_high = 1'b0;
        #16 link_clk = 1'b0;
    endtask : send_bit

    // Junk bits go out first so that only the last fourteen should count.
    task automatic send_word(input logic [13:0] w, input int junk);
        int i;
        #1;
        for (i = 0; i < junk + 14; i++) begin
            send_bit((i < junk) ? i[0] : w[i - junk]);
        end
        link_data = ~link_data;
    endtask : send_word

    task automatic end_word();
        supply_high = 1'b0;
        #EOW_NS;
    endtask : end_word

    task automatic exit_high();
        supply_high = 1'b1;
        #EXIT_NS;
        supply_high = 1'b0;
    endtask : exit_high
endmodule : tpp_programmer

// ### tpp_prog_tb.sv
/*
 * Self-checking bench for the PROM programming core with a behavioural
 * programmer. Assumes shortened entry, end-of-word and exit counts.
 */
`timescale 1ns/1ns
module tpp_prog_tb;
    import tpp_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n;
    logic       sync_entry;
    logic       field_above;
    logic       cal_done;
    logic       fuse_prog;
    logic       fuse_inv;
    logic [7:0] cal_thr;
    logic [7:0] field_lvl = 8'h5B;
    wire        link_clk, link_data, supply_high, pull_low;
    wire        q_o, q_oe, test_mode, sar_busy, burn, burn_inv;
    wire  [7:0] dac_code, burn_thr;
    wire  [2:0] burn_fac;
    wire        q_pin = (q_oe ? q_o : 1'b1) & ~pull_low;
    wire        dac_above = dac_code > field_lvl;
    int         err_total = 0;
    int         comparisons = 0;
    int         burn_cnt = 0;

    tpp_prog #(.ENTRY_LOW_CYC(20), .ENTRY_WIN_CYC(40), .EOW_CYC(30),
        .EXIT_CYC(60)) tpp_prog_i (
        .CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk),
        .LINK_DATA(link_data), .SUPPLY_HIGH(supply_high),
        .SYNC_ENTRY(sync_entry), .FIELD_ABOVE(field_above),
        .DAC_ABOVE(dac_above), .CAL_DONE(cal_done),
        .CAL_THRESHOLD(cal_thr), .FUSE_PROGRAMMED(fuse_prog),
        .FUSE_INV(fuse_inv), .Q_I(q_pin), .Q_O(q_o), .Q_OE(q_oe),
        .TEST_MODE(test_mode), .SAR_BUSY(sar_busy), .DAC_CODE(dac_code),
        .BURN(burn), .BURN_THRESHOLD(burn_thr), .BURN_FACTOR(burn_fac),
        .BURN_INV(burn_inv));

    tpp_programmer tpp_programmer_i (.link_clk(link_clk),
        .link_data(link_data), .supply_high(supply_high),
        .pull_low(pull_low));

    always #2 clk = ~clk;

    always @(posedge clk) begin
        if (burn === 1'b1) begin
            burn_cnt <= burn_cnt + 1;
        end
    end

    task automatic chk_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_vec(input string n, input logic [7:0] e,
                           input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk_vec

    task automatic wrap_up;
        $display("err_total %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic do_reset;
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
    endtask : do_reset

    // Don't-care bits vary with the factor so a decoder that uses them shows.
    task automatic copy_cmd(input logic [2:0] f, input logic inv,
                            input int junk);
        tpp_programmer_i.send_word({1'b1, HEAD_PATTERN, ~f, ~inv, f[1],
            f, inv, 1'b1}, junk);
        tpp_programmer_i.end_word();
        tpp_programmer_i.send_word({1'b1, COPY_WORD2}, 0);
        tpp_programmer_i.end_word();
        @(negedge clk);
    endtask : copy_cmd

    task automatic chk_burn(input int base, input logic [7:0] thr,
                            input logic [2:0] f, input logic inv);
        chk_vec("burn count", 8'h01, 8'(burn_cnt - base));
        chk_vec("burn threshold", thr, burn_thr);
        chk_vec("burn factor", {5'h00, f}, {5'h00, burn_fac});
        chk_bit("burn inversion", inv, burn_inv);
    endtask : chk_burn

    task automatic t_sync_copy;
        int i;
        int base;
        do_reset();
        cal_thr = 8'hC3;
        repeat (60) @(negedge clk);
        sync_entry = 1'b1;
        repeat (8) @(negedge clk);
        chk_bit("test mode", 1'b1, test_mode);
        base = burn_cnt;
        copy_cmd(3'h6, 1'b1, 0);
        chk_vec("burn before cal", 8'h00, 8'(burn_cnt - base));
        cal_done = 1'b1;
        tpp_programmer_i.send_word({1'b1, COPY_WORD2}, 0);
        tpp_programmer_i.end_word();
        @(negedge clk);
        chk_vec("lone word2", 8'h00, 8'(burn_cnt - base));
        for (i = 0; i < 8; i++) begin
            base = burn_cnt;
            copy_cmd(i[2:0], i[0], (i == 7) ? 2 : 0);
            chk_burn(base, 8'hC3, i[2:0], i[0]);
        end
        chk_bit("stay test", 1'b1, test_mode);
        tpp_programmer_i.exit_high();
        @(negedge clk);
        chk_bit("exit", 1'b0, test_mode);
        sync_entry = 1'b0;
        cal_done = 1'b0;
    endtask : t_sync_copy

    task automatic t_low_copy;
        int n;
        int base;
        tpp_programmer_i.hold_low(1'b1);
        do_reset();
        repeat (26) @(negedge clk);
        tpp_programmer_i.hold_low(1'b0);
        chk_bit("search busy", 1'b1, sar_busy);
        chk_bit("test entry", 1'b1, test_mode);
        n = 0;
        while (sar_busy === 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        // Busy rose two sync cycles plus the entry count after release,
        // and lasts eight internal clock periods; 26 were already waited.
        chk_vec("search span", 8'(2 + 20 + 8 * INT_CLK_CYC - 26), 8'(n));
        chk_vec("search result", field_lvl, dac_code);
        repeat (10 * INT_CLK_CYC) @(negedge clk);
        base = burn_cnt;
        copy_cmd(3'h3, 1'b0, 0);
        chk_burn(base, field_lvl, 3'h3, 1'b0);
        chk_bit("stay test", 1'b1, test_mode);
        fuse_prog = 1'b1;
        tpp_programmer_i.exit_high();
        @(negedge clk);
        chk_bit("exit", 1'b0, test_mode);
        field_above = 1'b1;
        repeat (8) @(negedge clk);
        chk_bit("inverted high", 1'b0, q_oe);
        field_above = 1'b0;
        repeat (8) @(negedge clk);
        chk_bit("inverted low", 1'b1, q_oe);
    endtask : t_low_copy

    task automatic t_refuse;
        tpp_programmer_i.hold_low(1'b1);
        do_reset();
        repeat (30) @(negedge clk);
        tpp_programmer_i.hold_low(1'b0);
        repeat (200) @(negedge clk);
        chk_bit("low entry refused", 1'b0, test_mode);
        sync_entry = 1'b1;
        repeat (10) @(negedge clk);
        chk_bit("sync entry refused", 1'b0, test_mode);
        fuse_inv = 1'b1;
        field_above = 1'b1;
        repeat (8) @(negedge clk);
        chk_bit("normal high", 1'b1, q_oe);
    endtask : t_refuse

    initial begin
        #200000;
        err_total++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        sync_entry = 1'b0;
        field_above = 1'b0;
        cal_done = 1'b0;
        fuse_prog = 1'b0;
        fuse_inv = 1'b0;
        cal_thr = 8'h00;
        t_sync_copy();
        t_low_copy();
        t_refuse();
        wrap_up();
    end
endmodule : tpp_prog_tb
